// File: readout_status_pkg.sv
/*
 * Constants shared by the status-word readout block: word size, bit positions
 * of the status word, per-mode global-sample lengths and window limits.
 * Assumes nothing of its surroundings; imported by the design modules.
 */
package readout_status_pkg;

    // word framing
    localparam logic [3:0] WORD_BITS = 4'hC;
    localparam logic [3:0] LAST_BIT = 4'hB;
    localparam logic [11:0] STATUS_RESET = 12'h000;

    // bit positions inside the status word
    localparam int ST_SYNC = 0;
    localparam int ST_ROW_VALID = 1;
    localparam int ST_FRAME_VALID = 2;
    localparam int ST_STATS_VALID = 3;
    localparam int ST_BLACK_REF_VALID = 4;
    localparam int ST_LONG_EXP = 5;
    localparam int ST_SHORT_EXP = 6;
    localparam int ST_GLOBAL_SAMPLE = 7;
    localparam int ST_EXP_UNSAFE = 8;
    localparam int ST_FRAME_UNSAFE = 9;
    localparam int ST_ZERO_LO = 10;
    localparam int ST_ZERO_HI = 11;

    // global-sample length in words for each image mode
    localparam logic [15:0] GLOBAL_SAMPLE_PHASE_LEN_DEFAULT_10B = 16'h005A;
    localparam logic [15:0] GLOBAL_SAMPLE_PHASE_LEN_SHORT_10B = 16'h001E;
    localparam logic [15:0] GLOBAL_SAMPLE_PHASE_LEN_SMALL_10B = 16'h0078;
    localparam logic [15:0] GLOBAL_SAMPLE_PHASE_LEN_DEFAULT_12B = 16'h005A;
    localparam logic [15:0] GLOBAL_SAMPLE_PHASE_LEN_SHORT_12B = 16'h001E;
    localparam logic [15:0] GLOBAL_SAMPLE_PHASE_LEN_BINNING_12B = 16'h0056;

    // vertical window limits; array height value is arbitrary
    localparam logic [11:0] SMALL_WIN_HALF_ROWS = 12'h0C8;
    localparam logic [11:0] SMALL_WIN_ROWS = 12'h190;
    localparam logic [11:0] ARRAY_ROWS = 12'hC00;

    // binning neighbour pitch
    localparam logic [1:0] BIN_PITCH_MONO = 2'h1;
    localparam logic [1:0] BIN_PITCH_COLOUR = 2'h2;

    typedef enum logic [2:0] {
        mode_default_10b,
        mode_short_exp_10b,
        mode_small_window_10b,
        mode_default_12b,
        mode_short_exp_12b,
        mode_binning_12b
    } mode_type;

endpackage

// File: lane_serializer.sv
/*
 * One output lane: loads a 12-bit word on the word strobe and shifts it out
 * LSB first, one bit per lane-clock edge.
 * Assumes bit_en and load come from the same ref_clk domain; load coincides
 * with the bit edge that starts a new word.
 */
`timescale 1ns/1ns
module lane_serializer (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic bit_en,
    input wire logic load,
    input wire logic [11:0] word,
    output logic lane
);
    import readout_status_pkg::*;

    logic [11:0] shift_r;

    // word load and bit shift, lsb first
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            shift_r <= STATUS_RESET;
            lane <= 1'b0;
        end else if (load) begin
            lane <= word[0];
            shift_r <= {1'b0, word[11:1]};
        end else if (bit_en) begin
            lane <= shift_r[0];
            shift_r <= {1'b0, shift_r[11:1]};
        end
    end

endmodule

// File: readout_status_word.sv
/*
 * Status-word generator of one readout side with a small exposure and readout
 * sequencer, image-mode settings and three serial lanes (status, first pixel,
 * black reference), all word-aligned.
 * Assumes lane_clk and exp_req come from outside and are synchronised here;
 * configuration inputs are static while a frame runs; pixel, black-reference
 * and statistics words are presented by the user and sampled at word_strobe.
 */
`timescale 1ns/1ns
module readout_status_word (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic lane_clk,
    input wire logic exp_req,
    input wire readout_status_pkg::mode_type image_mode,
    input wire logic colour_en,
    input wire logic safety_en,
    input wire logic lag_en,
    input wire logic [15:0] long_group_exposing_words,
    input wire logic [15:0] short_group_exposing_words,
    input wire logic [15:0] lag_words,
    input wire logic [15:0] overhead_words,
    input wire logic [15:0] row_words,
    input wire logic [15:0] gap_words,
    input wire logic [15:0] stats_words,
    input wire logic [11:0] num_rows,
    input wire logic [11:0] num_cols,
    input wire logic [11:0] pixel_word,
    input wire logic [11:0] black_ref_word,
    input wire logic [11:0] stats_word,
    output logic status_lane,
    output logic first_pixel_lane,
    output logic black_ref_lane,
    output logic word_strobe,
    output logic row_valid,
    output logic frame_valid,
    output logic stats_valid,
    output logic black_ref_valid,
    output logic long_group_exposing,
    output logic short_group_exposing,
    output logic global_sample_phase,
    output logic exposure_request_unsafe,
    output logic frame_request_unsafe,
    output logic exp_refused,
    output logic [11:0] read_rows,
    output logic [11:0] row_start,
    output logic [11:0] out_width,
    output logic [11:0] out_height,
    output logic [1:0] bin_pitch
);
    import readout_status_pkg::*;

    typedef enum logic [1:0] {EX_IDLE, EX_LAG, EX_EXPOSE} ex_state_type;
    typedef enum logic [2:0] {RD_IDLE, RD_GLOBAL_SAMPLE_PHASE, RD_OVER, RD_ROWS, RD_STATS} rd_state_type;

    logic lane_meta_r, lane_sync_r, lane_prev_r;
    logic req_meta_r, req_sync_r, req_prev_r;
    logic bit_en, word_en, req_rise;
    logic [3:0] bit_cnt_r;
    logic mode_short, mode_small, mode_bin, lag_on;
    logic [15:0] global_sample_phase_len;
    logic [11:0] rows_c, rows_eff;
    logic [15:0] row_words_eff, gap_eff, period_last, lag_eff, exp_eff, ovh_eff;
    ex_state_type ex_state_r;
    rd_state_type rd_state_r;
    logic [15:0] ex_cnt_r, rd_cnt_r, pos_r;
    logic [11:0] row_idx_r;
    logic req_pend_r, accept, take, rd_busy, rd_start;
    logic row_valid_c, frame_valid_c, obv_c;
    logic [11:0] status_word_c, status_word_r, pixel_word_c, black_word_c;

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers and edge detection

    // two flops per outside input, third flop for edges
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lane_meta_r <= 1'b0;
            lane_sync_r <= 1'b0;
            lane_prev_r <= 1'b0;
            req_meta_r <= 1'b0;
            req_sync_r <= 1'b0;
            req_prev_r <= 1'b0;
        end else begin
            lane_meta_r <= lane_clk;
            lane_sync_r <= lane_meta_r;
            lane_prev_r <= lane_sync_r;
            req_meta_r <= exp_req;
            req_sync_r <= req_meta_r;
            req_prev_r <= req_sync_r;
        end
    end

    // ddr lane clock: every edge carries one bit
    assign bit_en = lane_sync_r ^ lane_prev_r;
    assign req_rise = req_sync_r & ~req_prev_r;

    // bit position inside the current word
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bit_cnt_r <= LAST_BIT;
        end else if (bit_en) begin
            bit_cnt_r <= (bit_cnt_r == LAST_BIT) ? 4'h0 : bit_cnt_r + 4'h1;
        end
    end

    // all lanes load a new word on the same edge
    assign word_en = bit_en && (bit_cnt_r == LAST_BIT);
    assign word_strobe = word_en;

    ////////////////////////////////////////////////////////////////////////////
    // image-mode settings

    assign mode_short = (image_mode == mode_short_exp_10b) || (image_mode == mode_short_exp_12b);
    assign mode_small = (image_mode == mode_small_window_10b);
    assign mode_bin = (image_mode == mode_binning_12b);
    assign lag_on = lag_en || mode_short;

    // global-sample length per mode
    always_comb begin
        unique case (image_mode)
            mode_default_10b: global_sample_phase_len = GLOBAL_SAMPLE_PHASE_LEN_DEFAULT_10B;
            mode_short_exp_10b: global_sample_phase_len = GLOBAL_SAMPLE_PHASE_LEN_SHORT_10B;
            mode_small_window_10b: global_sample_phase_len = GLOBAL_SAMPLE_PHASE_LEN_SMALL_10B;
            mode_default_12b: global_sample_phase_len = GLOBAL_SAMPLE_PHASE_LEN_DEFAULT_12B;
            mode_short_exp_12b: global_sample_phase_len = GLOBAL_SAMPLE_PHASE_LEN_SHORT_12B;
            mode_binning_12b: global_sample_phase_len = GLOBAL_SAMPLE_PHASE_LEN_BINNING_12B;
            default: global_sample_phase_len = GLOBAL_SAMPLE_PHASE_LEN_DEFAULT_10B;
        endcase
    end

    // rows read out: clipped window or halved binned rows
    always_comb begin
        if (mode_small) begin
            rows_c = (num_rows > SMALL_WIN_ROWS) ? SMALL_WIN_ROWS : num_rows;
        end else if (mode_bin) begin
            rows_c = {1'b0, num_rows[11:1]};
        end else begin
            rows_c = num_rows;
        end
    end

    // geometry outputs registered for the user
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            read_rows <= 12'h000;
            row_start <= 12'h000;
            out_width <= 12'h000;
            out_height <= 12'h000;
            bin_pitch <= 2'h0;
        end else begin
            read_rows <= rows_c;
            // centred window around the array middle
            row_start <= mode_small ? (ARRAY_ROWS >> 1) - {1'b0, rows_c[11:1]} : 12'h000;
            out_height <= rows_c;
            out_width <= mode_bin ? {1'b0, num_cols[11:1]} : num_cols;
            // same-colour neighbours are two apart in colour mode
            bin_pitch <= !mode_bin ? 2'h0 : (colour_en ? BIN_PITCH_COLOUR : BIN_PITCH_MONO);
        end
    end

    // zero settings are taken as one word or row
    assign rows_eff = (rows_c == 12'h000) ? 12'h001 : rows_c;
    assign row_words_eff = (row_words == 16'h0000) ? 16'h0001 : row_words;
    assign gap_eff = (gap_words == 16'h0000) ? 16'h0001 : gap_words;
    assign period_last = 16'(row_words_eff + gap_eff - 16'h0001);
    assign lag_eff = (lag_words == 16'h0000) ? 16'h0001 : lag_words;
    assign exp_eff = (long_group_exposing_words == 16'h0000) ? 16'h0001 : long_group_exposing_words;
    assign ovh_eff = (overhead_words == 16'h0000) ? 16'h0001 : overhead_words;

    ////////////////////////////////////////////////////////////////////////////
    // exposure request and exposure sequencer

    assign rd_busy = (rd_state_r != RD_IDLE);
    assign accept = (ex_state_r == EX_IDLE) && !(mode_short && rd_busy);
    assign take = word_en && (ex_state_r == EX_IDLE);
    assign rd_start = word_en && (ex_state_r == EX_EXPOSE) && (ex_cnt_r <= 16'h0001) && !rd_busy;

    // pending request; a new request beats the take
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            req_pend_r <= 1'b0;
            exp_refused <= 1'b0;
        end else begin
            exp_refused <= req_rise && !accept;
            if (req_rise && accept) begin
                req_pend_r <= 1'b1;
            end else if (take) begin
                req_pend_r <= 1'b0;
            end
        end
    end

    // lag when lag_en is set or in short mode, then long-group integration ending into global sample
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ex_state_r <= EX_IDLE;
            ex_cnt_r <= 16'h0000;
        end else if (word_en) begin
            unique case (ex_state_r)
                EX_IDLE: begin
                    if (req_pend_r && lag_on) begin
                        ex_state_r <= EX_LAG;
                        ex_cnt_r <= lag_eff;
                    end else if (req_pend_r) begin
                        ex_state_r <= EX_EXPOSE;
                        ex_cnt_r <= exp_eff;
                    end
                end
                EX_LAG: begin
                    if (ex_cnt_r <= 16'h0001) begin
                        ex_state_r <= EX_EXPOSE;
                        ex_cnt_r <= exp_eff;
                    end else begin
                        ex_cnt_r <= ex_cnt_r - 16'h0001;
                    end
                end
                EX_EXPOSE: begin
                    // overlap: integration holds until the previous readout ends
                    if (ex_cnt_r > 16'h0001) begin
                        ex_cnt_r <= ex_cnt_r - 16'h0001;
                    end else if (!rd_busy) begin
                        ex_state_r <= EX_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // readout sequencer

    // global sample, overhead, rows with leading black row, statistics
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_state_r <= RD_IDLE;
            rd_cnt_r <= 16'h0000;
            row_idx_r <= 12'h000;
            pos_r <= 16'h0000;
        end else if (word_en) begin
            unique case (rd_state_r)
                RD_IDLE: begin
                    if (rd_start) begin
                        rd_state_r <= RD_GLOBAL_SAMPLE_PHASE;
                        rd_cnt_r <= 16'(global_sample_phase_len - 16'h0001);
                    end
                end
                RD_GLOBAL_SAMPLE_PHASE: begin
                    if (rd_cnt_r == 16'h0000) begin
                        rd_state_r <= RD_OVER;
                        rd_cnt_r <= 16'(ovh_eff - 16'h0001);
                    end else begin
                        rd_cnt_r <= rd_cnt_r - 16'h0001;
                    end
                end
                RD_OVER: begin
                    if (rd_cnt_r == 16'h0000) begin
                        rd_state_r <= RD_ROWS;
                        row_idx_r <= 12'h000;
                        pos_r <= 16'h0000;
                    end else begin
                        rd_cnt_r <= rd_cnt_r - 16'h0001;
                    end
                end
                RD_ROWS: begin
                    if (pos_r != period_last) begin
                        pos_r <= pos_r + 16'h0001;
                    end else if (row_idx_r != rows_eff) begin
                        pos_r <= 16'h0000;
                        row_idx_r <= row_idx_r + 12'h001;
                    end else begin
                        pos_r <= 16'h0000;
                        rd_state_r <= (stats_words == 16'h0000) ? RD_IDLE : RD_STATS;
                        rd_cnt_r <= 16'(stats_words - 16'h0001);
                    end
                end
                RD_STATS: begin
                    if (rd_cnt_r == 16'h0000) begin
                        rd_state_r <= RD_IDLE;
                    end else begin
                        rd_cnt_r <= rd_cnt_r - 16'h0001;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status word and lane words

    // period k carries pixels of row k and black data of row k+1
    assign row_valid_c = (rd_state_r == RD_ROWS) && (row_idx_r != 12'h000) && (pos_r < row_words_eff);
    assign obv_c = (rd_state_r == RD_ROWS) && (row_idx_r < rows_eff) && (pos_r < row_words_eff);
    assign frame_valid_c = (rd_state_r == RD_ROWS) && (row_idx_r != 12'h000)
        && ((row_idx_r < rows_eff) || (pos_r < row_words_eff));

    // assemble the next status word
    always_comb begin
        status_word_c = STATUS_RESET;
        status_word_c[ST_SYNC] = 1'b1;
        status_word_c[ST_ROW_VALID] = row_valid_c;
        status_word_c[ST_FRAME_VALID] = frame_valid_c;
        status_word_c[ST_STATS_VALID] = (rd_state_r == RD_STATS);
        status_word_c[ST_BLACK_REF_VALID] = obv_c;
        status_word_c[ST_LONG_EXP] = (ex_state_r == EX_EXPOSE);
        status_word_c[ST_SHORT_EXP] = (ex_state_r == EX_EXPOSE) && (ex_cnt_r <= short_group_exposing_words);
        status_word_c[ST_GLOBAL_SAMPLE] = (rd_state_r == RD_GLOBAL_SAMPLE_PHASE);
        status_word_c[ST_EXP_UNSAFE] = safety_en
            && ((ex_state_r != EX_IDLE) || req_pend_r || (mode_short && rd_busy));
        status_word_c[ST_FRAME_UNSAFE] = safety_en && rd_busy;
    end

    // statistics only on the first lane; black data only on its own lane
    assign pixel_word_c = (rd_state_r == RD_STATS) ? stats_word : (row_valid_c ? pixel_word : 12'h000);
    assign black_word_c = obv_c ? black_ref_word : 12'h000;

    // status word held for the flag outputs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            status_word_r <= STATUS_RESET;
        end else if (word_en) begin
            status_word_r <= status_word_c;
        end
    end

    assign row_valid = status_word_r[ST_ROW_VALID];
    assign frame_valid = status_word_r[ST_FRAME_VALID];
    assign stats_valid = status_word_r[ST_STATS_VALID];
    assign black_ref_valid = status_word_r[ST_BLACK_REF_VALID];
    assign long_group_exposing = status_word_r[ST_LONG_EXP];
    assign short_group_exposing = status_word_r[ST_SHORT_EXP];
    assign global_sample_phase = status_word_r[ST_GLOBAL_SAMPLE];
    assign exposure_request_unsafe = status_word_r[ST_EXP_UNSAFE];
    assign frame_request_unsafe = status_word_r[ST_FRAME_UNSAFE];

    // three word-aligned lanes
    lane_serializer status_ser (
        .ref_clk(ref_clk), .rst(rst), .bit_en(bit_en), .load(word_en),
        .word(status_word_c), .lane(status_lane)
    );
    lane_serializer pixel_ser (
        .ref_clk(ref_clk), .rst(rst), .bit_en(bit_en), .load(word_en),
        .word(pixel_word_c), .lane(first_pixel_lane)
    );
    lane_serializer black_ser (
        .ref_clk(ref_clk), .rst(rst), .bit_en(bit_en), .load(word_en),
        .word(black_word_c), .lane(black_ref_lane)
    );

    ////////////////////////////////////////////////////////////////////////////
    // assertions and covers

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    AST_FRAMING: assert property (word_en |=> status_word_r[ST_SYNC] && !status_word_r[ST_ZERO_LO]
        && !status_word_r[ST_ZERO_HI]) else $error("status word framing bits wrong");
    AST_FIRST_BIT: assert property (word_en |=> status_lane == status_word_r[ST_SYNC])
        else $error("status lane does not start with bit 0");
    AST_ROW_IN_FRAME: assert property (row_valid |-> frame_valid)
        else $error("row valid outside frame valid");
    AST_FRAME_EDGES: assert property ($rose(frame_valid) |-> $rose(row_valid))
        else $error("frame valid rose without row valid");
    AST_FRAME_FALL: assert property ($fell(frame_valid) |-> $fell(row_valid))
        else $error("frame valid fell apart from row valid");
    AST_ROW_GAP: assert property (word_en && row_valid_c && (pos_r == 16'h0000) |-> !row_valid)
        else $error("no gap word between rows");
    AST_STATS_ALONE: assert property (stats_valid |-> !row_valid && !black_ref_valid)
        else $error("statistics overlap pixel data");
    AST_GLOBAL_SAMPLE_PHASE_OVERHEAD: assert property ($fell(global_sample_phase) |-> !frame_valid [*8])
        else $error("frame valid too soon after global sample");
    AST_SHORT_INSIDE: assert property (short_group_exposing |-> long_group_exposing)
        else $error("short group exposing outside long group");
    AST_SHORT_REFUSE: assert property (mode_short && rd_busy && req_rise |=> exp_refused && !req_pend_r)
        else $error("exposure accepted during short-mode readout");
    AST_SHORT_LAG: assert property (mode_short && take && req_pend_r |=> ex_state_r == EX_LAG)
        else $error("short mode skipped shutter lag");
    AST_WINDOW: assert property (mode_small && $past(mode_small) |-> read_rows <= SMALL_WIN_ROWS)
        else $error("small window taller than allowed");

    COV_FRAME: cover property ($rose(frame_valid));
    COV_STATS: cover property ($fell(stats_valid));
    COV_DUAL: cover property (long_group_exposing && !short_group_exposing ##[1:1000] short_group_exposing);
    COV_REFUSE: cover property (exp_refused);

endmodule

// File: lane_receiver.sv
/* receiver model: deserialises status, first pixel and black-reference lanes.
   assumes each lane bit stands four ref_clk cycles */
`timescale 1ns/1ns
module lane_receiver (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic word_strobe,
    input wire logic status_lane,
    input wire logic first_pixel_lane,
    input wire logic black_ref_lane,
    output logic [11:0] rx_status,
    output logic [11:0] rx_pixel,
    output logic [11:0] rx_black,
    output logic rx_done
);
    logic [5:0] cnt_r;
    // words are framed by word_strobe, not by a training word
    // samples mid-bit, lsb first, status like pixel lane
    always_ff @(posedge ref_clk) begin
        rx_done <= (cnt_r == 6'h2E);
        if (rst) begin
            cnt_r <= 6'h3F;
        end else if (word_strobe) begin
            cnt_r <= 6'h00;
        end else if (cnt_r != 6'h3F) begin
            cnt_r <= cnt_r + 6'h01;
        end
        if (cnt_r < 6'h2E && cnt_r[1:0] == 2'h1) begin
            rx_status <= {status_lane, rx_status[11:1]};
            rx_pixel <= {first_pixel_lane, rx_pixel[11:1]};
            rx_black <= {black_ref_lane, rx_black[11:1]};
        end
    end
endmodule

// File: tb.sv
/* bench: one frame per image mode, word counts and geometry.
   assumes the lane_receiver model beside the design */
`timescale 1ns/1ns
module tb;
    import readout_status_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, lane_clk = 1'b0, exp_req = 1'b0;
    logic colour_en = 1'b1, safety_en = 1'b1, lag_en = 1'b0;
    mode_type image_mode = mode_default_10b;
    // three-word exposure stays far inside 100 us in the short modes
    logic [15:0] long_group_exposing_words = 16'h0003, short_group_exposing_words = 16'h0001, lag_words = 16'h0001;
    logic [15:0] overhead_words = 16'h0002, row_words = 16'h0002, gap_words = 16'h0001;
    logic [15:0] stats_words = 16'h0002;
    logic [11:0] num_rows = 12'h002, num_cols = 12'h064, pixel_word = 12'hA5C;
    logic [11:0] black_ref_word = 12'h3C1, stats_word = 12'h5F0;
    logic status_lane, first_pixel_lane, black_ref_lane, word_strobe, row_valid, frame_valid;
    logic stats_valid, black_ref_valid, long_group_exposing, short_group_exposing;
    logic global_sample_phase, exposure_request_unsafe, frame_request_unsafe, exp_refused, rx_done;
    logic [11:0] read_rows, row_start, out_width, out_height, rx_status, rx_pixel, rx_black;
    logic [1:0] bin_pitch;
    logic [5:0] fl;
    logic [15:0] cnt [7];
    int fails = 0, n_compared = 0, cyc = 0, re;
    int global_sample_phase_t [6] = '{90, 30, 120, 90, 30, 86};
    readout_status_word dut_u (.*);
    lane_receiver rx_u (.*);
    assign fl = {long_group_exposing, black_ref_valid, stats_valid, frame_valid, row_valid, global_sample_phase};
    always #20 ref_clk = ~ref_clk;
    always #160 lane_clk = ~lane_clk;
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic words(input int n);
        repeat (n) @(posedge ref_clk iff word_strobe === 1'b1);
    endtask
    task automatic pulse();
        @(posedge ref_clk);
        exp_req <= 1'b1;
        repeat (4) @(posedge ref_clk);
        exp_req <= 1'b0;
    endtask
    // per-word counts of flags, per-cycle count of refusals, word checks, timeout
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            fails++;
            summarize();
        end
        cnt[6] <= cnt[6] + 16'(exp_refused);
        if (word_strobe === 1'b1)
            for (int i = 0; i < 6; i++)
                cnt[i] <= cnt[i] + 16'(fl[i]);
        if (rx_done === 1'b1) begin
            chk("framing", 1, rx_status & 12'hC01);
            chk("flags", {frame_request_unsafe, exposure_request_unsafe, global_sample_phase,
                short_group_exposing, fl[5:1]}, rx_status[9:1]);
            if (rx_status[1])
                chk("pixel", pixel_word, rx_pixel);
            if (rx_status[3])
                chk("stats", stats_word, rx_pixel);
            if (rx_status[4])
                chk("black_word", black_ref_word, rx_black);
        end
    end
    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        for (int m = 0; m < 6; m++) begin
            image_mode <= mode_type'(m);
            @(negedge ref_clk);
            foreach (cnt[i]) cnt[i] = 16'h0;
            pulse();
            words(40);
            if (m == 1 || m == 4)
                pulse();
            words(110);
            re = (m == 5) ? 1 : 2;
            chk("global_sample_phase", global_sample_phase_t[m], cnt[0]);
            chk("rows", 2 * re, cnt[1]);
            chk("frame_valid", 3 * re - 1, cnt[2]);
            chk("stats_valid", 2, cnt[3]);
            chk("black", 2 * re, cnt[4]);
            chk("long", 3, cnt[5]);
            chk("refused", (m == 1 || m == 4), cnt[6]);
            chk("read_rows", re, read_rows);
            $display("test mode %0d done", m);
        end
        num_rows <= 12'h1F4;
        image_mode <= mode_small_window_10b;
        repeat (3) @(posedge ref_clk);
        chk("win_rows", 400, read_rows);
        chk("win_start", 1336, row_start);
        image_mode <= mode_binning_12b;
        repeat (3) @(posedge ref_clk);
        chk("bin_rows", 250, out_height);
        chk("bin_width", 50, out_width);
        chk("bin_pitch", 2, bin_pitch);
        colour_en <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk("bin_mono", 1, bin_pitch);
        $display("test geometry done");
        summarize();
    end
endmodule
